// File: src/wwr_pkg.sv
// Constants and types of the window watchdog reset block
//
// What this block does
// - Trigger counts only if low longer than 7 us; shorter pulses ignored.
// - Missing valid trigger in the required interval produces a reset pulse.
// - Lead time for the first trigger lasts 3948 oscillator periods.
// - Closed window is 553 periods, open window 527 periods.
// - Watchdog is fully off while the device sleeps.
// - Active low-power mode granted only with the disable bit set.
// - Disable bit becomes one only after two consecutive command words write one.
// - Divider strap high through the 4 ms startup starts the watchdog disabled.
// - After power-up reset is held low 4 ms, then released and lead starts.
// - After sleep exit the lead time starts at the rising reset edge.
// - A valid trigger during lead time starts the closed window at once.
// - Lead time expiry without trigger gives a 4 ms watchdog reset.
// - A valid trigger in the open window starts a new closed window.
// - Open window elapsing without trigger pulls reset low.
// - A valid trigger in the closed window pulls reset low immediately.
// - Faulty timing resistor keeps producing resets unless watchdog disabled.
package wwr_pkg;

    // ------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TRIG_MIN_NS    = 7000;
    localparam int TRIG_MIN_CYC   = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_TIME_NS  = 4000000;
    localparam int RESET_TIME_CYC = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_PERIOD_NS  = 39900;
    localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FAULT_OSC_CYC  = 64;

    // ------------------------------------------------------------
    // Window lengths in oscillator periods
    // ------------------------------------------------------------
    localparam int          WIN_W      = 12;
    localparam logic [11:0] LEAD_PER   = 12'hF6C;
    localparam logic [11:0] CLOSED_PER = 12'h229;
    localparam logic [11:0] OPEN_PER   = 12'h20F;
    localparam int          RCNT_W     = 20;
    localparam int          OSC_W      = 16;
    localparam int          TRIG_W     = 12;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_STARTUP = 6'h01,
        ST_LEAD    = 6'h02,
        ST_CLOSED  = 6'h04,
        ST_OPEN    = 6'h08,
        ST_WDRESET = 6'h10,
        ST_OFF     = 6'h20
    } wwr_state_t;

    // ------------------------------------------------------------
    // Configuration command word
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic wd_disable;
    } wwr_cfg_cmd_t;

endpackage

// File: src/wwr_trig_filter.sv
// Trigger glitch filter: one pulse per low phase longer than the minimum
module wwr_trig_filter #(
    parameter int MIN_CYC = wwr_pkg::TRIG_MIN_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Trigger pin
    input  wire logic wd_trigger_n_i,
    // Accepted trigger
    output logic      valid_o
);

    logic [wwr_pkg::TRIG_W-1:0] cnt_reg;
    logic [wwr_pkg::TRIG_W-1:0] cnt_next;
    logic                       fired_reg;
    logic                       fired_next;
    logic                       valid_reg;
    logic                       valid_next;

    // ------------------------------------------------------------
    // Low-phase measurement
    // ------------------------------------------------------------
    always_comb begin
        cnt_next   = cnt_reg;
        fired_next = fired_reg;
        valid_next = 1'b0;
        if (wd_trigger_n_i) begin
            cnt_next   = '0;
            fired_next = 1'b0;
        end else if (!fired_reg) begin
            if (cnt_reg == wwr_pkg::TRIG_W'(MIN_CYC)) begin
                valid_next = 1'b1;
                fired_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= '0;
            fired_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            fired_reg <= fired_next;
            valid_reg <= valid_next;
        end
    end

    assign valid_o = valid_reg;

endmodule

// File: src/wwr_osc_tick.sv
// Watchdog oscillator model: one tick per oscillator period
module wwr_osc_tick #(
    parameter int PERIOD_CYC = wwr_pkg::OSC_PERIOD_CYC,
    parameter int FAULT_CYC  = wwr_pkg::FAULT_OSC_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic restart_i,
    input  wire logic fault_i,
    // Tick
    output logic      tick_o
);

    logic [wwr_pkg::OSC_W-1:0] cnt_reg;
    logic [wwr_pkg::OSC_W-1:0] cnt_next;
    logic [wwr_pkg::OSC_W-1:0] last;
    logic                      tick_reg;
    logic                      tick_next;

    // ------------------------------------------------------------
    // Period divider
    // ------------------------------------------------------------
    always_comb begin
        last      = fault_i ? wwr_pkg::OSC_W'(FAULT_CYC - 1) : wwr_pkg::OSC_W'(PERIOD_CYC - 1);
        cnt_next  = cnt_reg + 1'b1;
        tick_next = 1'b0;
        if (restart_i) begin
            cnt_next = '0;
        end else if (cnt_reg >= last) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule

// File: src/wwr_top.sv
// Window watchdog with reset output, disable logic and low-power gate
module wwr_top #(
    parameter int RESET_CYC  = wwr_pkg::RESET_TIME_CYC,
    parameter int OSC_CYC    = wwr_pkg::OSC_PERIOD_CYC,
    parameter int FAULT_CYC  = wwr_pkg::FAULT_OSC_CYC,
    parameter int TRIG_CYC   = wwr_pkg::TRIG_MIN_CYC
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // Host trigger
    input  wire logic                  wd_trigger_n_i,
    // Straps and fault
    input  wire logic                  divider_strap_pin_i,
    input  wire logic                  osc_resistor_pin_i,
    // Mode control
    input  wire logic                  sleep_i,
    input  wire logic                  lp_request_i,
    // Configuration command word
    input  wire wwr_pkg::wwr_cfg_cmd_t cfg_cmd_i,
    // Reset pin, open drain
    output logic                       reset_n_o,
    output logic                       reset_n_oe_o,
    // Status
    output logic                       wd_disable_bit_o,
    output logic                       strap_disabled_o,
    output logic                       wd_running_o,
    output logic                       lp_grant_o
);

    wwr_pkg::wwr_state_t         state_reg;
    wwr_pkg::wwr_state_t         state_next;
    logic [wwr_pkg::RCNT_W-1:0]  rcnt_reg;
    logic [wwr_pkg::RCNT_W-1:0]  rcnt_next;
    logic [wwr_pkg::WIN_W-1:0]   wcnt_reg;
    logic [wwr_pkg::WIN_W-1:0]   wcnt_next;
    logic                        dis_bit_reg;
    logic                        dis_bit_next;
    logic                        dis_pend_reg;
    logic                        dis_pend_next;
    logic                        strap_reg;
    logic                        strap_next;
    logic                        rst_out_reg;
    logic                        rst_out_next;
    logic                        run_reg;
    logic                        run_next;
    logic                        lp_reg;
    logic                        lp_next;
    logic                        trig_valid;
    logic                        tick;
    logic                        tick_restart;
    logic                        disabled;
    logic                        rcnt_done;
    logic                        win_last;

    // ------------------------------------------------------------
    // Trigger filter and oscillator
    // ------------------------------------------------------------
    wwr_trig_filter #(
        .MIN_CYC        (TRIG_CYC)
    ) u_trig (
        .ref_clk_i      (ref_clk_i),
        .rst_n_i        (rst_n_i),
        .wd_trigger_n_i (wd_trigger_n_i),
        .valid_o        (trig_valid)
    );

    wwr_osc_tick #(
        .PERIOD_CYC     (OSC_CYC),
        .FAULT_CYC      (FAULT_CYC)
    ) u_osc (
        .ref_clk_i      (ref_clk_i),
        .rst_n_i        (rst_n_i),
        .restart_i      (tick_restart),
        .fault_i        (osc_resistor_pin_i),
        .tick_o         (tick)
    );

    // ------------------------------------------------------------
    // Disable bit with double write
    // ------------------------------------------------------------
    always_comb begin
        dis_bit_next  = dis_bit_reg;
        dis_pend_next = dis_pend_reg;
        if (cfg_cmd_i.write) begin
            if (cfg_cmd_i.wd_disable) begin
                dis_pend_next = 1'b1;
                if (dis_pend_reg) begin
                    dis_bit_next = 1'b1;
                end
            end else begin
                dis_pend_next = 1'b0;
                dis_bit_next  = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dis_bit_reg  <= 1'b0;
            dis_pend_reg <= 1'b0;
        end else begin
            dis_bit_reg  <= dis_bit_next;
            dis_pend_reg <= dis_pend_next;
        end
    end

    assign disabled = dis_bit_reg | strap_reg;

    // ------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------
    assign rcnt_done = (rcnt_reg == wwr_pkg::RCNT_W'(RESET_CYC - 1));

    always_comb begin
        state_next   = state_reg;
        rcnt_next    = rcnt_reg;
        wcnt_next    = wcnt_reg;
        strap_next   = strap_reg;
        tick_restart = 1'b0;
        win_last     = 1'b0;
        case (state_reg)
            wwr_pkg::ST_STARTUP: begin
                rcnt_next = rcnt_reg + 1'b1;
                if (rcnt_done) begin
                    strap_next   = divider_strap_pin_i;
                    rcnt_next    = '0;
                    wcnt_next    = '0;
                    tick_restart = 1'b1;
                    state_next   = (divider_strap_pin_i | dis_bit_reg) ?
                                   wwr_pkg::ST_OFF : wwr_pkg::ST_LEAD;
                end
            end
            wwr_pkg::ST_LEAD: begin
                win_last = (wcnt_reg == wwr_pkg::WIN_W'(wwr_pkg::LEAD_PER - 1'b1));
                if (trig_valid) begin
                    wcnt_next    = '0;
                    tick_restart = 1'b1;
                    state_next   = osc_resistor_pin_i ?
                                   wwr_pkg::ST_WDRESET : wwr_pkg::ST_CLOSED;
                end else if (tick) begin
                    wcnt_next = wcnt_reg + 1'b1;
                    if (win_last) begin
                        state_next = wwr_pkg::ST_WDRESET;
                    end
                end
            end
            wwr_pkg::ST_CLOSED: begin
                win_last = (wcnt_reg == wwr_pkg::WIN_W'(wwr_pkg::CLOSED_PER - 1'b1));
                if (trig_valid) begin
                    state_next = wwr_pkg::ST_WDRESET;
                end else if (tick) begin
                    wcnt_next = wcnt_reg + 1'b1;
                    if (win_last) begin
                        wcnt_next  = '0;
                        state_next = wwr_pkg::ST_OPEN;
                    end
                end
            end
            wwr_pkg::ST_OPEN: begin
                win_last = (wcnt_reg == wwr_pkg::WIN_W'(wwr_pkg::OPEN_PER - 1'b1));
                if (trig_valid) begin
                    wcnt_next    = '0;
                    tick_restart = 1'b1;
                    state_next   = osc_resistor_pin_i ?
                                   wwr_pkg::ST_WDRESET : wwr_pkg::ST_CLOSED;
                end else if (tick) begin
                    wcnt_next = wcnt_reg + 1'b1;
                    if (win_last) begin
                        state_next = wwr_pkg::ST_WDRESET;
                    end
                end
            end
            wwr_pkg::ST_WDRESET: begin
                rcnt_next = rcnt_reg + 1'b1;
                if (rcnt_done) begin
                    rcnt_next    = '0;
                    wcnt_next    = '0;
                    tick_restart = 1'b1;
                    state_next   = disabled ? wwr_pkg::ST_OFF : wwr_pkg::ST_LEAD;
                end
            end
            wwr_pkg::ST_OFF: begin
                if (!disabled) begin
                    wcnt_next    = '0;
                    tick_restart = 1'b1;
                    state_next   = wwr_pkg::ST_LEAD;
                end
            end
            default: begin
                rcnt_next  = '0;
                state_next = wwr_pkg::ST_STARTUP;
            end
        endcase
        if (disabled && (state_reg != wwr_pkg::ST_STARTUP) &&
            (state_reg != wwr_pkg::ST_WDRESET)) begin
            state_next = wwr_pkg::ST_OFF;
        end
        if (sleep_i) begin
            rcnt_next  = '0;
            wcnt_next  = '0;
            strap_next = 1'b0;
            state_next = wwr_pkg::ST_STARTUP;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= wwr_pkg::ST_STARTUP;
            rcnt_reg  <= '0;
            wcnt_reg  <= '0;
            strap_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rcnt_reg  <= rcnt_next;
            wcnt_reg  <= wcnt_next;
            strap_reg <= strap_next;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_comb begin
        rst_out_next = (state_next == wwr_pkg::ST_STARTUP) ||
                       (state_next == wwr_pkg::ST_WDRESET);
        run_next     = (state_next == wwr_pkg::ST_LEAD) ||
                       (state_next == wwr_pkg::ST_CLOSED) ||
                       (state_next == wwr_pkg::ST_OPEN);
        lp_next      = lp_request_i & dis_bit_next & ~sleep_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rst_out_reg <= 1'b1;
            run_reg     <= 1'b0;
            lp_reg      <= 1'b0;
        end else begin
            rst_out_reg <= rst_out_next;
            run_reg     <= run_next;
            lp_reg      <= lp_next;
        end
    end

    assign reset_n_o        = 1'b0;
    assign reset_n_oe_o     = rst_out_reg;
    assign wd_disable_bit_o = dis_bit_reg;
    assign strap_disabled_o = strap_reg;
    assign wd_running_o     = run_reg;
    assign lp_grant_o       = lp_reg;

endmodule

// File: sim/wwr_top_sva.sv
// Assertions on the ports of the window watchdog reset block
module wwr_top_chk #(
    parameter int RESET_CYC = 40,
    parameter int FAULT_CYC = 2
) (
    // Clock and reset
    input wire logic                  ref_clk_i,
    input wire logic                  rst_n_i,
    // Inputs watched
    input wire logic                  osc_resistor_pin_i,
    input wire logic                  sleep_i,
    input wire logic                  lp_request_i,
    input wire wwr_pkg::wwr_cfg_cmd_t cfg_cmd_i,
    // Outputs watched
    input wire logic                  reset_n_o,
    input wire logic                  reset_n_oe_o,
    input wire logic                  wd_disable_bit_o,
    input wire logic                  strap_disabled_o,
    input wire logic                  wd_running_o,
    input wire logic                  lp_grant_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FAULT_LIM = int'(wwr_pkg::LEAD_PER) * FAULT_CYC + 64;
    localparam int RC_LO     = RESET_CYC - 2;
    localparam int RC_HI     = RESET_CYC + 2;

    logic [19:0] hi_reg;
    logic [19:0] hi_next;
    logic [19:0] flt_reg;
    logic [19:0] flt_next;
    logic [1:0]  ones_reg;
    logic [1:0]  ones_next;

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    always_comb begin
        hi_next   = (reset_n_oe_o && !sleep_i) ? hi_reg + 20'h00001 : 20'h00000;
        flt_next  = (osc_resistor_pin_i && !reset_n_oe_o && !wd_disable_bit_o && !strap_disabled_o && !sleep_i) ?
                    flt_reg + 20'h00001 : 20'h00000;
        ones_next = ones_reg;
        if (cfg_cmd_i.write) begin
            ones_next = !cfg_cmd_i.wd_disable ? 2'h0 : ((ones_reg == 2'h2) ? 2'h2 : ones_reg + 2'h1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hi_reg   <= 20'h00000;
            flt_reg  <= 20'h00000;
            ones_reg <= 2'h0;
        end else begin
            hi_reg   <= hi_next;
            flt_reg  <= flt_next;
            ones_reg <= ones_next;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_lp_needs_wdd: assert property (lp_grant_o
        |-> wd_disable_bit_o && $past(lp_request_i) && !$past(sleep_i))
        else $error("low-power grant without disable bit");
    a_lp_grant_on: assert property (lp_request_i && !sleep_i |=> lp_grant_o == wd_disable_bit_o)
        else $error("low-power grant missing");
    a_sleep_wd_off: assert property (sleep_i [*3] |-> !wd_running_o)
        else $error("watchdog running in sleep");
    a_sleep_pin_low: assert property (sleep_i [*3] |-> reset_n_oe_o)
        else $error("reset pin released in sleep");
    a_wdd_two_writes: assert property ($rose(wd_disable_bit_o) |-> ones_reg == 2'h2 && $past(cfg_cmd_i.write))
        else $error("disable bit set without two writes");
    a_quiet_disabled: assert property ((wd_disable_bit_o || strap_disabled_o) && !reset_n_oe_o && !sleep_i
        |=> !reset_n_oe_o)
        else $error("reset while watchdog disabled");
    a_pin_data_low: assert property (reset_n_oe_o |-> !reset_n_o)
        else $error("reset pin data not low");
    a_pulse_len: assert property ($fell(reset_n_oe_o) |-> hi_reg >= RC_LO && hi_reg <= RC_HI)
        else $error("reset pulse length wrong");
    a_idle_in_reset: assert property (reset_n_oe_o [*3] |-> !wd_running_o)
        else $error("watchdog running during reset pulse");
    a_fault_repeats: assert property (flt_reg < FAULT_LIM)
        else $error("no reset with faulty timing resistor");
endmodule

bind wwr_top wwr_top_chk #(.RESET_CYC(RESET_CYC), .FAULT_CYC(FAULT_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .osc_resistor_pin_i(osc_resistor_pin_i), .sleep_i(sleep_i),
    .lp_request_i(lp_request_i), .cfg_cmd_i(cfg_cmd_i), .reset_n_o(reset_n_o), .reset_n_oe_o(reset_n_oe_o),
    .wd_disable_bit_o(wd_disable_bit_o), .strap_disabled_o(strap_disabled_o), .wd_running_o(wd_running_o),
    .lp_grant_o(lp_grant_o));

// File: sim/wwr_host_model.sv
// Host model: trigger pulses to the watchdog, reacting to the reset pin
module wwr_host_model (
    // Clock and control
    input  wire logic        ref_clk_i,
    input  wire logic        go_i,
    input  wire logic [15:0] len_i,
    // Watchdog pins
    input  wire logic        reset_pin_i,
    output logic             trig_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    initial trig_n_o = 1'b1;

    // Falling-edge pulse, low for len_i clocks, dropped on reset
    always @(negedge ref_clk_i) begin
        if (!reset_pin_i) begin
            trig_n_o <= 1'b1;
            cnt      <= 0;
        end else if (cnt > 0) begin
            cnt      <= cnt - 1;
            trig_n_o <= (cnt == 1);
        end else if (go_i) begin
            trig_n_o <= 1'b0;
            cnt      <= len_i;
        end
    end
endmodule

// File: sim/test_window_watchdog_reset.sv
// Bench for the window watchdog reset block
module test_window_watchdog_reset;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Reduced timing and expected figures
    // ------------------------------------------------------------
    localparam int RC   = 40;
    localparam int OC   = 4;
    localparam int FC   = 2;
    localparam int TC   = 3;
    localparam int LEAD = 3948 * OC;
    localparam int CLS  = 553 * OC;
    localparam int WIN  = (553 + 527) * OC;

    logic                  clk       = 1'b0;
    logic                  rst_n     = 1'b0;
    logic                  strap     = 1'b0;
    logic                  fault     = 1'b0;
    logic                  sleep     = 1'b0;
    logic                  lp_req    = 1'b0;
    logic                  go        = 1'b0;
    logic [15:0]           len       = 16'h0000;
    wwr_pkg::wwr_cfg_cmd_t cfg       = '0;
    logic                  trig_n;
    logic                  oe;
    logic                  rn;
    logic                  wd_disable_bit;
    logic                  strap_dis;
    logic                  running;
    logic                  lp_grant;
    wire                   pin;
    int                    err_total = 0;
    int                    checks    = 0;
    int                    n;
    int                    exp_q[$];

    always #4 clk = ~clk;
    assign pin = oe ? rn : 1'b1;

    wwr_top #(.RESET_CYC(RC), .OSC_CYC(OC), .FAULT_CYC(FC), .TRIG_CYC(TC)) dut_u (
        .ref_clk_i(clk), .rst_n_i(rst_n), .wd_trigger_n_i(trig_n), .divider_strap_pin_i(strap),
        .osc_resistor_pin_i(fault), .sleep_i(sleep), .lp_request_i(lp_req), .cfg_cmd_i(cfg),
        .reset_n_o(rn), .reset_n_oe_o(oe), .wd_disable_bit_o(wd_disable_bit), .strap_disabled_o(strap_dis),
        .wd_running_o(running), .lp_grant_o(lp_grant));

    wwr_host_model host_u (.ref_clk_i(clk), .go_i(go), .len_i(len), .reset_pin_i(pin), .trig_n_o(trig_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task step(input logic v);
        int e;
        e = exp_q.pop_front();
        n = 0;
        while (oe !== v && n < 20000) begin
            @(negedge clk);
            n++;
        end
        checks++;
        if (n < e - 6 || n > e + 6) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, n, e);
        end
    endtask

    task trig(input int l);
        @(negedge clk);
        go  <= 1'b1;
        len <= 16'(l);
        @(negedge clk);
        go  <= 1'b0;
    endtask

    task wr(input logic d);
        @(negedge clk);
        cfg <= '{write: 1'b1, wd_disable: d};
        @(negedge clk);
        cfg.write <= 1'b0;
    endtask

    task results;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #(8 * 90000);
        err_total++;
        results();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(38850));
        repeat (20) @(negedge clk);
        rst_n  = 1'b1;
        exp_q  = '{RC, LEAD, RC};
        step(1'b0);
        step(1'b1);
        step(1'b0);
        repeat (10) @(negedge clk);
        trig(TC + 4);
        repeat (100) @(negedge clk);
        trig(1 + $urandom % TC);
        repeat (30) @(negedge clk);
        chk(oe, 1'b0);
        exp_q = '{TC + 3, RC};
        trig(TC + 4);
        step(1'b1);
        step(1'b0);
        trig(TC + 4);
        repeat (CLS + 20 + $urandom % 1500) @(negedge clk);
        chk(oe, 1'b0);
        exp_q = '{WIN + TC + 3, RC};
        trig(TC + 4);
        step(1'b1);
        step(1'b0);
        lp_req = 1'b1;
        wr(1'b1);
        wr(1'b0);
        wr(1'b1);
        repeat (3) @(negedge clk);
        chk(wd_disable_bit, 1'b0);
        chk(lp_grant, 1'b0);
        chk(running, 1'b1);
        wr(1'b1);
        repeat (3) @(negedge clk);
        chk(wd_disable_bit, 1'b1);
        chk(lp_grant, 1'b1);
        chk(running, 1'b0);
        fault = 1'b1;
        repeat (9000) @(negedge clk);
        chk(oe, 1'b0);
        exp_q = '{3948 * FC, RC, 3948 * FC, RC, LEAD};
        wr(1'b0);
        step(1'b1);
        step(1'b0);
        step(1'b1);
        fault  = 1'b0;
        lp_req = 1'b0;
        sleep  = 1'b1;
        repeat (5 + $urandom % 50) @(negedge clk);
        chk(running, 1'b0);
        chk(oe, 1'b1);
        sleep = 1'b0;
        step(1'b0);
        step(1'b1);
        strap = 1'b1;
        sleep = 1'b1;
        repeat (5) @(negedge clk);
        sleep = 1'b0;
        repeat (RC + 10) @(negedge clk);
        chk(strap_dis, 1'b1);
        chk(running, 1'b0);
        strap = 1'b0;
        repeat (200) @(negedge clk);
        chk(oe, 1'b0);
        results();
    end
endmodule
